// file: verilog/burst_sram_pkg.sv
// constants, access states and the registered state record of the
// flow-through burst static memory.
// assumes: one clock, everything here shared by the memory core files.
package burst_sram_pkg;

  // ---------------------------------------------------------------
  // array organisation (wide variant)
  // ---------------------------------------------------------------
  localparam int ADDR_W = 18;
  localparam int DATA_W = 36;
  localparam int LANE_W = 9;
  localparam int LANES = 4;
  localparam int DEPTH = 262144;
  localparam int BURST_W = 2;
  localparam int UPPER_W = ADDR_W - BURST_W;

  // ---------------------------------------------------------------
  // burst counter and reset values
  // ---------------------------------------------------------------
  localparam logic [BURST_W-1:0] BURST_START = 2'h0;
  localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
  localparam logic [DATA_W-1:0] DATA_RST = 36'h000000000;
  localparam logic [LANES-1:0] LANES_NONE = 4'h0;

  // ---------------------------------------------------------------
  // access state, one-hot
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_DESEL = 4'b0001,
    OP_READ = 4'b0010,
    OP_WRITE = 4'b0100,
    OP_SLEEP = 4'b1000
  } op_t;

  typedef struct packed {
    op_t op;
    logic [ADDR_W-1:0] addr;
    logic [BURST_W-1:0] base_lo;
    logic [BURST_W-1:0] cnt;
    logic wr_pend;
    logic [ADDR_W-1:0] wr_addr;
    logic [LANES-1:0] wr_lanes;
    logic [DATA_W-1:0] dout;
    logic drive;
    logic interleave;
    logic strap_done;
    logic low_power;
  } state_t;

  localparam state_t STATE_RST = '{
    op: OP_DESEL,
    addr: ADDR_RST,
    base_lo: BURST_START,
    cnt: BURST_START,
    wr_pend: 1'b0,
    wr_addr: ADDR_RST,
    wr_lanes: LANES_NONE,
    dout: DATA_RST,
    drive: 1'b0,
    interleave: 1'b0,
    strap_done: 1'b0,
    low_power: 1'b1
  };

endpackage

// file: verilog/level_sync3.sv
// three-stage synchroniser for an asynchronous level input.
// assumes: the filtered level moves only when stages one and two agree.
`timescale 1ns/1ps

module level_sync3 (
  // clock, reset, enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // level in and filtered level out
  input wire logic level_in,
  output logic level_out
);

  logic [2:0] stage_r;
  logic level_r;

  // ---------------------------------------------------------------
  // stage chain; stage zero feeds stage one only
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      stage_r <= 3'h0;
      level_r <= 1'b0;
    end else if (ce) begin
      stage_r <= {stage_r[1:0], level_in};
      if (stage_r[1] == stage_r[2]) begin // both settled stages agree
        level_r <= stage_r[2];
      end
    end
  end

  assign level_out = level_r;

endmodule // level_sync3

// file: verilog/burst_sram.sv
// flow-through burst static memory core with back-to-back read/write.
// assumes: master logic runs on clk; sleep request is asynchronous; the
// burst order strap is stable from reset onward.
`timescale 1ns/1ps

// Summary of operation
// - all synchronous inputs are registered on the rising clock edge.
// - clock qualify high freezes every state bit; master uses it to stall.
// - reads and writes mix freely, one word per enabled cycle, no dead cycle.
// - write strobe plus active-low lane selects; only selected lanes are written.
// - selected only when first and third selects low and second high.
// - output enable gates the data drivers without waiting for the clock.
// - drivers stay off during the data phase of a write.
// - driver timing follows access type, so output enable may stay asserted.
// - burst addresses follow linear or interleaved order per strap.
// - sleep request or deselection puts the core in low power.
// - array holds 256K words of 36 bits.
module burst_sram
  import burst_sram_pkg::*;
(
  // clock, reset, stall
  input wire logic clk,
  input wire logic resetn,
  input wire logic clock_qualify_n,
  // address and access control
  input wire logic [UPPER_W-1:0] addr_upper,
  input wire logic burst_addr_bit_one,
  input wire logic burst_addr_bit_zero,
  input wire logic advance_or_load,
  input wire logic write_enable_n,
  input wire logic [LANES-1:0] byte_lane_write_n,
  // chip selects
  input wire logic chip_select_first_n,
  input wire logic chip_select_second,
  input wire logic chip_select_third_n,
  // power and strap
  input wire logic sleep_request,
  input wire logic burst_order_interleave,
  // data pins, split into in, out and enable
  input wire logic output_enable_n,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe,
  // status
  output logic low_power
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------

  // all three selects must be active at once
  function automatic logic chip_selected(input logic first_n, input logic second,
                                         input logic third_n);
    chip_selected = !first_n && second && !third_n;
  endfunction

  // low address bits for burst step cnt from the loaded base
  function automatic logic [BURST_W-1:0] burst_lo(input logic [BURST_W-1:0] base,
                                                  input logic [BURST_W-1:0] cnt,
                                                  input logic interleave);
    if (interleave) begin
      burst_lo = base ^ cnt;
    end else begin
      burst_lo = base + cnt;
    end
  endfunction

  // replace only the enabled nine-bit lanes of old with new
  function automatic logic [DATA_W-1:0] merge_lanes(input logic [DATA_W-1:0] old_word,
                                                    input logic [DATA_W-1:0] new_word,
                                                    input logic [LANES-1:0] lanes);
    logic [DATA_W-1:0] res;
    res = old_word;
    for (int i = 0; i < LANES; i++) begin
      if (lanes[i]) begin
        res[i*LANE_W +: LANE_W] = new_word[i*LANE_W +: LANE_W];
      end
    end
    merge_lanes = res;
  endfunction

  // ---------------------------------------------------------------
  // storage and state
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] mem [0:DEPTH-1];
  state_t st_r;
  state_t st_nxt;
  logic ce;
  logic sleep_sync;
  logic selected;
  logic [ADDR_W-1:0] load_addr;
  logic [BURST_W-1:0] cnt_step;
  logic [DATA_W-1:0] array_word;

  // stall input freezes every register, including the synchroniser
  assign ce = !clock_qualify_n;

  assign load_addr = {addr_upper, burst_addr_bit_one, burst_addr_bit_zero};
  assign selected = chip_selected(chip_select_first_n, chip_select_second,
                                  chip_select_third_n);

  // ---------------------------------------------------------------
  // sleep request synchroniser
  // ---------------------------------------------------------------
  level_sync3 u_sleep_sync (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .level_in(sleep_request),
    .level_out(sleep_sync)
  );

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------

  // decide this edge's access; read data leaves the array at the same edge
  always_comb begin
    st_nxt = st_r;
    cnt_step = st_r.cnt + BURST_STEP;
    array_word = DATA_RST;
    // a write's data phase lasts exactly one enabled cycle
    st_nxt.wr_pend = 1'b0;
    // strap caught on the first enabled edge after reset release
    if (!st_r.strap_done) begin
      st_nxt.interleave = burst_order_interleave;
      st_nxt.strap_done = 1'b1;
    end
    if (sleep_sync) begin
      // sleep overrides everything; a pending write still finishes below
      st_nxt.op = OP_SLEEP;
    end else if (!advance_or_load) begin
      // load cycle: fresh address, type and selection
      if (selected) begin
        st_nxt.op = write_enable_n ? OP_READ : OP_WRITE;
        st_nxt.addr = load_addr;
        st_nxt.base_lo = load_addr[BURST_W-1:0];
        st_nxt.cnt = BURST_START;
      end else begin
        st_nxt.op = OP_DESEL;
      end
    end else begin
      // advance cycle: repeat the access type on the next burst address
      case (st_r.op)
        OP_READ, OP_WRITE: begin
          st_nxt.cnt = cnt_step;
          st_nxt.addr[BURST_W-1:0] = burst_lo(st_r.base_lo, cnt_step,
                                              st_nxt.interleave);
        end
        OP_SLEEP: begin
          st_nxt.op = OP_DESEL; // an advance cannot restart a burst after sleep
        end
        OP_DESEL: begin
          st_nxt.op = OP_DESEL;
        end
        default: begin
          st_nxt.op = OP_DESEL;
        end
      endcase
    end
    // output window and write capture follow the chosen access type
    case (st_nxt.op)
      OP_READ: begin
        array_word = mem[st_nxt.addr];
        // write data arriving now for the same word must be seen at once
        if (st_r.wr_pend && (st_r.wr_addr == st_nxt.addr)) begin
          array_word = merge_lanes(array_word, dq_in, st_r.wr_lanes);
        end
        st_nxt.dout = array_word;
        st_nxt.drive = 1'b1;
      end
      OP_WRITE: begin
        st_nxt.wr_pend = 1'b1;
        st_nxt.wr_addr = st_nxt.addr;
        st_nxt.wr_lanes = ~byte_lane_write_n;
        st_nxt.drive = 1'b0;
      end
      OP_DESEL, OP_SLEEP: begin
        st_nxt.drive = 1'b0;
      end
      default: begin
        st_nxt.drive = 1'b0;
      end
    endcase
    st_nxt.low_power = (st_nxt.op == OP_SLEEP) || (st_nxt.op == OP_DESEL);
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------

  // input capture; stalled edges leave everything untouched
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_r <= STATE_RST;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // array write port
  // ---------------------------------------------------------------

  // data phase: the word registered one enabled edge after its address;
  // the array has no reset, like real static storage
  always_ff @(posedge clk) begin
    if (resetn && ce && st_r.wr_pend) begin
      mem[st_r.wr_addr] <= merge_lanes(mem[st_r.wr_addr], dq_in, st_r.wr_lanes);
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign dq_out = st_r.dout;
  // gating is deliberately unclocked so output enable acts at once
  assign dq_oe = st_r.drive && !output_enable_n;
  assign low_power = st_r.low_power;

endmodule // burst_sram

// file: test/burst_sram_assertions.sv
// checker for the burst memory core: drive, stall and power timing at the ports.
// assumes: bound to burst_sram; one clock, synchronous active-low reset.
`timescale 1ns/1ps
module burst_sram_assertions
  import burst_sram_pkg::*;
(
  // clock, reset, stall
  input wire logic clk,
  input wire logic resetn,
  input wire logic clock_qualify_n,
  // access control
  input wire logic advance_or_load,
  input wire logic write_enable_n,
  input wire logic chip_select_first_n,
  input wire logic chip_select_second,
  input wire logic chip_select_third_n,
  input wire logic sleep_request,
  input wire logic output_enable_n,
  // outputs
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic dq_oe,
  input wire logic low_power
);
  logic [2:0] quiet_r;
  logic sel;
  logic go;
  // --------
  // helpers
  // --------
  // the sleep synchroniser lags, so reads only count after quiet edges
  always_ff @(posedge clk) begin
    if (sleep_request) begin
      quiet_r <= 3'h0;
    end else if (!clock_qualify_n && (!resetn || quiet_r != 3'h7)) begin
      quiet_r <= resetn ? quiet_r + 3'h1 : 3'h7;
    end
  end
  assign sel = !chip_select_first_n && chip_select_second && !chip_select_third_n;
  assign go = !clock_qualify_n && !advance_or_load;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence wr_s; go && !write_enable_n && sel && quiet_r == 3'h7; endsequence
  sequence rd_s; go && write_enable_n && sel && quiet_r == 3'h7; endsequence
  // --------
  // assertions
  // --------
  chk_stall_hold: assert property (
    clock_qualify_n |=> $stable(dq_out) && $stable(low_power)) else $error("stall moved outputs");
  chk_oe_async: assert property (
    output_enable_n |-> !dq_oe) else $error("drive with output enable off");
  chk_write_float: assert property (
    go && !write_enable_n |=> !dq_oe) else $error("drive in write data phase");
  chk_read_drive: assert property (
    rd_s |=> (dq_oe || output_enable_n) && !low_power) else $error("read not driven");
  chk_write_read: assert property (
    wr_s ##1 rd_s |=> dq_oe || output_enable_n) else $error("dead cycle after write");
  chk_deselect_idle: assert property (
    go && !sel |=> low_power && !dq_oe) else $error("deselect not idle");
  chk_sleep_power: assert property (
    (sleep_request && !clock_qualify_n) [*6] |=> low_power && !dq_oe) else $error("no sleep");
  chk_write_burst: assert property (
    wr_s ##1 (!clock_qualify_n && advance_or_load) |=> !dq_oe) else $error("burst write drove");
  chk_read_burst: assert property (
    rd_s ##1 (!clock_qualify_n && advance_or_load) |=> dq_oe || output_enable_n)
    else $error("burst read not driven");
  cover property (rd_s);
  cover property (wr_s ##1 rd_s);
  cover property (clock_qualify_n [*2]);
endmodule // burst_sram_assertions

// file: test/sram_master_model.sv
// master side of the data lines: write data in the data phase only.
// assumes: the bench raises wv for the cycle after a write address cycle.
`timescale 1ns/1ps
module sram_master_model
  import burst_sram_pkg::*;
(
  // clock
  input wire logic clk,
  // write data from the bench
  input wire logic wv,
  input wire logic [DATA_W-1:0] wd,
  // memory side of the wire
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic dq_oe,
  output logic [DATA_W-1:0] dq_in
);
  logic [DATA_W-1:0] last_r;
  // released lines flip each cycle so stale data never passes as good
  always_ff @(posedge clk) begin
    last_r <= dq_in;
  end
  // wire level: memory driver, else master data held to the taking edge
  assign dq_in = dq_oe ? dq_out : wv ? wd : ~last_r;
endmodule // sram_master_model

// file: test/burst_sram_tb.sv
// bench for burst_sram: access table, then stall, enable, strap and sleep.
// assumes: 50 ns clock, master model on the data lines, checker bound below.
`timescale 1ns/1ps
module burst_sram_tb
  import burst_sram_pkg::*;
;
  localparam logic [2:0] ON = 3'h2;
  localparam logic [DATA_W-1:0] W0 = 36'h123456789;
  localparam logic [DATA_W-1:0] W1 = 36'hABCDE0F01;
  localparam logic [DATA_W-1:0] W2 = {W1[DATA_W-1:LANE_W], 9'h1FF};
  localparam logic [DATA_W-1:0] F = 36'hFFFFFFFFF;
  typedef struct packed {
    logic adv, we_n;
    logic [2:0] cs;
    logic [ADDR_W-1:0] a;
    logic [LANES-1:0] ln;
    logic wv;
    logic [DATA_W-1:0] wd;
    logic e_oe;
    logic [DATA_W-1:0] e_do;
  } row_t;
  logic clk = 1'b0, resetn = 1'b0, clock_qualify_n = 1'b0, advance_or_load = 1'b0;
  logic write_enable_n = 1'b1, sleep_request = 1'b0, burst_order_interleave = 1'b0;
  logic output_enable_n = 1'b0, wv = 1'b0, dq_oe, low_power;
  logic [2:0] cs = 3'h6;
  logic [ADDR_W-1:0] a = 18'h00000;
  logic [LANES-1:0] byte_lane_write_n = 4'hF;
  logic [DATA_W-1:0] wd = 36'h000000000, dq_in, dq_out;
  int errors = 0, total_checks = 0;
  // write 4,5 by burst, read back across the turn, lane write, deselects
  row_t rows [10] = '{
    '{1'b0, 1'b0, ON, 18'h00004, 4'h0, 1'b0, W0, 1'b0, W0},
    '{1'b1, 1'b0, ON, 18'h00004, 4'h0, 1'b1, W0, 1'b0, W0},
    '{1'b0, 1'b1, ON, 18'h00004, 4'hF, 1'b1, W1, 1'b1, W0},
    '{1'b1, 1'b1, ON, 18'h00004, 4'hF, 1'b0, W1, 1'b1, W1},
    '{1'b0, 1'b0, ON, 18'h00005, 4'hE, 1'b0, W1, 1'b0, W1},
    '{1'b0, 1'b1, ON, 18'h00005, 4'hF, 1'b1, F, 1'b1, W2},
    '{1'b0, 1'b1, 3'h6, 18'h00005, 4'hF, 1'b0, W1, 1'b0, W1},
    '{1'b0, 1'b1, 3'h0, 18'h00005, 4'hF, 1'b0, W1, 1'b0, W1},
    '{1'b0, 1'b1, 3'h3, 18'h00005, 4'hF, 1'b0, W1, 1'b0, W1},
    '{1'b0, 1'b1, ON, 18'h00004, 4'hF, 1'b0, W1, 1'b1, W0}};

  burst_sram u_dut (.clk, .resetn, .clock_qualify_n, .addr_upper(a[ADDR_W-1:BURST_W]),
    .burst_addr_bit_one(a[1]), .burst_addr_bit_zero(a[0]), .advance_or_load,
    .write_enable_n, .byte_lane_write_n, .chip_select_first_n(cs[2]),
    .chip_select_second(cs[1]), .chip_select_third_n(cs[0]), .sleep_request,
    .burst_order_interleave, .output_enable_n, .dq_in, .dq_out, .dq_oe, .low_power);
  sram_master_model u_master (.clk, .wv, .wd, .dq_out, .dq_oe, .dq_in);

  always #25 clk = ~clk;

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // one read access, taken at the following edge
  task automatic go(input logic adv_i, input logic [ADDR_W-1:0] a_i);
    @(posedge clk);
    advance_or_load <= adv_i;
    write_enable_n <= 1'b1;
    cs <= ON;
    a <= a_i;
    wv <= 1'b0;
  endtask

  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    check(dq_oe, 1'b0);
    check(low_power, 1'b1);
    // row i is taken at the edge after it is driven, checked at the falling edge after that
    for (int i = 0; i <= 10; i++) begin
      @(posedge clk);
      if (i < 10) begin
        {advance_or_load, write_enable_n, cs, a} <= {rows[i].adv, rows[i].we_n, rows[i].cs, rows[i].a};
        {byte_lane_write_n, wv, wd} <= {rows[i].ln, rows[i].wv, rows[i].wd};
      end
      @(negedge clk);
      if (i > 0) begin
        check(dq_oe, rows[i-1].e_oe);
        check(low_power, rows[i-1].cs !== ON);
        if (rows[i-1].e_oe) check(dq_out, rows[i-1].e_do);
      end
    end
    // stall with a burst advance waiting, enable dropped mid-stall
    go(1'b0, 18'h00004);
    @(posedge clk);
    advance_or_load <= 1'b1;
    clock_qualify_n <= 1'b1;
    @(negedge clk);
    check(dq_oe, 1'b1);
    @(posedge clk);
    output_enable_n <= 1'b1;
    #1 check(dq_oe, 1'b0);
    @(posedge clk);
    output_enable_n <= 1'b0;
    clock_qualify_n <= 1'b0;
    @(negedge clk);
    check(dq_out, W0);
    @(negedge clk);
    check(dq_out, W2);
    // strap is caught after reset: burst from 5 goes 5 then 4
    @(posedge clk);
    resetn <= 1'b0;
    burst_order_interleave <= 1'b1;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    go(1'b0, 18'h00005);
    go(1'b1, 18'h00005);
    @(negedge clk);
    check(dq_out, W2);
    @(negedge clk);
    check(dq_out, W0);
    // sleep must win within a bounded number of edges
    @(posedge clk);
    sleep_request <= 1'b1;
    for (int n = 0; n < 8 && low_power !== 1'b1; n++) @(negedge clk);
    check(low_power, 1'b1);
    repeat (4) @(posedge clk);
    @(negedge clk);
    check(dq_oe, 1'b0);
    summarize();
  end
endmodule // burst_sram_tb

bind burst_sram burst_sram_assertions u_chk (.clk, .resetn, .clock_qualify_n, .advance_or_load,
  .write_enable_n, .chip_select_first_n, .chip_select_second, .chip_select_third_n,
  .sleep_request, .output_enable_n, .dq_out, .dq_oe, .low_power);
